// ===== hw/gcm_global_config.sv
`timescale 1ns/1ps
module gcm_global_config
  import gcm_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYC
) (
  // Clock and reset.
  input  wire logic                          SYS_CLK_IN,
  input  wire logic                          RST_IN,
  // Register port from the serial front end.
  input  wire logic                          REG_WR_IN,
  input  wire logic                          REG_RD_IN,
  input  wire logic [7:0]                    REG_ADDR_IN,
  input  wire logic [7:0]                    REG_WDATA_IN,
  output logic      [7:0]                    REG_RDATA_OUT,
  // External reset pin and device reset.
  input  wire logic                          RESET_PIN_N_IN,
  output logic                               DEVICE_RESET_OUT,
  // Status flags and open-drain interrupt pin.
  input  wire logic [7:0]                    STATUS_FLAGS_IN,
  input  wire logic                          IRQ_CLEAR_IN,
  input  wire logic                          IRQ_PIN_IN,
  output logic                               IRQ_PIN_OUT,
  output logic                               IRQ_PIN_OE_OUT,
  // Oscillator and core clock.
  output logic                               OSC_RUN_OUT,
  output logic                               CORE_TICK_OUT,
  // Row pull-up strength.
  output logic                               ROW_PULL_STRONG_OUT,
  // Balls.
  input  wire logic [NBALL-1:0]              KEYPAD_SEL_IN,
  input  gcm_pkg::gcm_ball_drive_type [NBALL-1:0] BALL_DRIVE_IN,
  input  wire logic [NBALL-1:0]              BALL_PAD_IN,
  output logic      [NBALL-1:0]              BALL_PAD_OUT,
  output logic      [NBALL-1:0]              BALL_PAD_OE_OUT,
  output logic      [NBALL-1:0]              GPIO_IN_OUT,
  // Alternate function sources and sink.
  input  wire logic                          PULSE_ONE_IN,
  input  wire logic                          PULSE_TWO_IN,
  input  wire logic                          RESET_GEN_IN,
  input  wire logic                          LOGIC_OUT_IN,
  output logic                               LOGIC_THIRD_INPUT_OUT
);

  import gcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////

  logic [7:0]        pin_ext_ff;
  logic [7:0]        global_ff;
  logic [7:0]        irq_mask_ff;
  logic              dev_rst_ff;
  logic              core_rst;
  logic              wr_pin_ext;
  logic              wr_global;
  logic              wr_irq_mask;
  logic              soft_req;
  logic              pin_req;
  logic              pending;
  logic              clr_start;
  logic [HOLD_W-1:0] hold_cnt_ff;
  logic [HOLD_W-1:0] nxt_hold_cnt;
  logic [7:0]        nxt_rdata;
  logic [NBALL-1:0]  alt_en;
  logic [NBALL-1:0]  alt_is_in;
  logic [NBALL-1:0]  alt_src;
  logic [NBALL-1:0]  mux_o;
  logic [NBALL-1:0]  mux_oe;
  logic [NBALL-1:0]  mux_gpio_i;
  logic [NBALL-1:0]  mux_alt_i;
  logic              tick;

  ////////////////////////////////////////////////////////////////////////
  // Reset control
  ////////////////////////////////////////////////////////////////////////

  // Register writes decoded from the address.
  assign wr_pin_ext  = REG_WR_IN && (REG_ADDR_IN == ADDR_PIN_EXT);
  assign wr_global   = REG_WR_IN && (REG_ADDR_IN == ADDR_GLOBAL);
  assign wr_irq_mask = REG_WR_IN && (REG_ADDR_IN == ADDR_IRQ_MASK);

  assign soft_req = wr_global && REG_WDATA_IN[SOFT_BIT];

  assign pin_req  = !RESET_PIN_N_IN && !global_ff[PIN_IGN_BIT];

  // The device reset is one cycle late, so the write that asks for it
  // still lands but is wiped on the next edge.
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      dev_rst_ff <= 1'b0;
    end else begin
      dev_rst_ff <= soft_req | pin_req;
    end
  end

  assign core_rst         = RST_IN | dev_rst_ff;
  assign DEVICE_RESET_OUT = dev_rst_ff;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////

  // Pin function extension register; reserved bits never store.
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      pin_ext_ff <= RST_PIN_EXT;
    end else if (wr_pin_ext) begin
      pin_ext_ff <= REG_WDATA_IN & WMASK_PIN_EXT;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      global_ff <= RST_GLOBAL;
    end else if (wr_global) begin
      global_ff <= REG_WDATA_IN & WMASK_GLOBAL;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      irq_mask_ff <= RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask_ff <= REG_WDATA_IN & WMASK_IRQ;
    end
  end

  // Read mux; unmapped addresses answer zero.
  always_comb begin
    case (REG_ADDR_IN)
      ADDR_PIN_EXT:  nxt_rdata = pin_ext_ff;
      ADDR_GLOBAL:   nxt_rdata = global_ff;
      ADDR_IRQ_MASK: nxt_rdata = irq_mask_ff;
      default:       nxt_rdata = READ_ZERO;
    endcase
  end

  // Read data is captured on the read strobe and then held.
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= READ_ZERO;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt line
  ////////////////////////////////////////////////////////////////////////

  assign pending = |(STATUS_FLAGS_IN & irq_mask_ff & WMASK_IRQ);

  assign clr_start = IRQ_CLEAR_IN && pending && global_ff[CLR_CFG_BIT];

  // Release window counter; a clear inside the window restarts it.
  always_comb begin
    if (clr_start) begin
      nxt_hold_cnt = HOLD_W'(HOLDOFF_CYCLES);
    end else if (hold_cnt_ff != '0) begin
      nxt_hold_cnt = hold_cnt_ff - HOLD_W'(1);
    end else begin
      nxt_hold_cnt = '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      hold_cnt_ff <= '0;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      IRQ_PIN_OE_OUT <= 1'b0;
    end else begin
      IRQ_PIN_OE_OUT <= pending && (nxt_hold_cnt == '0);
    end
  end

  // Open drain: only ever pulls low, the enable carries the state.
  always_ff @(posedge SYS_CLK_IN) begin
    IRQ_PIN_OUT <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator, core clock and pull strength
  ////////////////////////////////////////////////////////////////////////

  gcm_clk_div u_clk_div (
    .clk_in    (SYS_CLK_IN),
    .rst_in    (core_rst),
    .osc_on_in (global_ff[OSC_ON_BIT]),
    .sel_in    (global_ff[CSEL_HI_BIT:CSEL_LO_BIT]),
    .tick_out  (tick)
  );

  // Tick already comes from a flop; this stage keeps outputs aligned.
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      CORE_TICK_OUT <= 1'b0;
      OSC_RUN_OUT   <= 1'b0;
    end else begin
      CORE_TICK_OUT <= tick;
      OSC_RUN_OUT   <= global_ff[OSC_ON_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      ROW_PULL_STRONG_OUT <= 1'b0;
    end else begin
      ROW_PULL_STRONG_OUT <= pin_ext_ff[PULL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ball alternate functions
  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    alt_en             = '0;
    alt_is_in          = '0;
    alt_src            = '0;
    alt_en[BALL_COL0]    = pin_ext_ff[COL0_ALT_BIT];
    alt_src[BALL_COL0]   = PULSE_ONE_IN;
    alt_en[BALL_COL1]    = pin_ext_ff[COL1_ALT_BIT];
    alt_src[BALL_COL1]   = PULSE_TWO_IN;
    alt_en[BALL_ROW0]    = pin_ext_ff[ROW0_ALT_BIT];
    alt_src[BALL_ROW0]   = LOGIC_OUT_IN;
    alt_en[BALL_ROW3]    = pin_ext_ff[ROW3_ALT_BIT];
    alt_is_in[BALL_ROW3] = 1'b1;
    alt_en[BALL_ROW4]    = pin_ext_ff[ROW4_ALT_BIT];
    alt_src[BALL_ROW4]   = RESET_GEN_IN;
  end

  for (genvar b = 0; b < NBALL; b++) begin : g_ball
    gcm_ball_mux u_mux (
      .keypad_sel_in   (KEYPAD_SEL_IN[b]),
      .alt_en_in       (alt_en[b]),
      .alt_is_input_in (alt_is_in[b]),
      .gpio_o_in       (BALL_DRIVE_IN[b].gpio_o),
      .gpio_oe_in      (BALL_DRIVE_IN[b].gpio_oe),
      .scan_o_in       (BALL_DRIVE_IN[b].scan_o),
      .scan_oe_in      (BALL_DRIVE_IN[b].scan_oe),
      .alt_o_in        (alt_src[b]),
      .pad_in          (BALL_PAD_IN[b]),
      .pad_o_out       (mux_o[b]),
      .pad_oe_out      (mux_oe[b]),
      .gpio_i_out      (mux_gpio_i[b]),
      .alt_i_out       (mux_alt_i[b])
    );
  end

  // Ball outputs are registered, which costs one cycle of latency on
  // pulse edges but keeps the pads glitch free.
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst) begin
      BALL_PAD_OUT          <= '0;
      BALL_PAD_OE_OUT       <= '0;
      GPIO_IN_OUT           <= '0;
      LOGIC_THIRD_INPUT_OUT <= 1'b0;
    end else begin
      BALL_PAD_OUT          <= mux_o;
      BALL_PAD_OE_OUT       <= mux_oe;
      GPIO_IN_OUT           <= mux_gpio_i;
      LOGIC_THIRD_INPUT_OUT <= mux_alt_i[BALL_ROW3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_clear_hold;
    IRQ_CLEAR_IN && pending && global_ff[CLR_CFG_BIT] && !dev_rst_ff;
  endsequence

  sequence s_released;
    !IRQ_PIN_OE_OUT [*8];
  endsequence

  a_pull_follows: assert property (
    !core_rst ##1 !core_rst
    |-> ROW_PULL_STRONG_OUT == $past(pin_ext_ff[PULL_BIT]))
    else $error("row pull strength does not follow its bit");

  a_col0_pulse: assert property (
    (pin_ext_ff[COL0_ALT_BIT] && !KEYPAD_SEL_IN[BALL_COL0] && !core_rst)
    |=> (BALL_PAD_OE_OUT[BALL_COL0] &&
         BALL_PAD_OUT[BALL_COL0] == $past(PULSE_ONE_IN)))
    else $error("column zero ball not driving pulse one");

  a_row4_reset: assert property (
    (pin_ext_ff[ROW4_ALT_BIT] && !KEYPAD_SEL_IN[BALL_ROW4] && !core_rst)
    |=> (BALL_PAD_OUT[BALL_ROW4] == $past(RESET_GEN_IN)))
    else $error("row four ball not driving reset generator");

  a_row3_input: assert property (
    (pin_ext_ff[ROW3_ALT_BIT] && !KEYPAD_SEL_IN[BALL_ROW3] && !core_rst)
    |=> (!BALL_PAD_OE_OUT[BALL_ROW3] &&
         LOGIC_THIRD_INPUT_OUT == $past(BALL_PAD_IN[BALL_ROW3])))
    else $error("row three ball not feeding logic input");

  a_keypad_wins: assert property (
    (KEYPAD_SEL_IN[BALL_ROW0] && !core_rst)
    |=> BALL_PAD_OE_OUT[BALL_ROW0] == $past(BALL_DRIVE_IN[BALL_ROW0].scan_oe))
    else $error("alternate function overrode keypad mode");

  a_osc_stopped: assert property (
    (!global_ff[OSC_ON_BIT]) [*3] |=> !CORE_TICK_OUT)
    else $error("core tick while oscillator is off");

  a_soft_reset: assert property (
    soft_req |=> DEVICE_RESET_OUT ##1 (global_ff == RST_GLOBAL))
    else $error("soft reset did not reset the device");

  a_pin_ignored: assert property (
    (!RESET_PIN_N_IN && global_ff[PIN_IGN_BIT] && !soft_req)
    |=> !DEVICE_RESET_OUT)
    else $error("reset pin acted while ignored");

  a_pin_resets: assert property (
    (!RESET_PIN_N_IN && !global_ff[PIN_IGN_BIT]) |=> DEVICE_RESET_OUT)
    else $error("reset pin low did not reset device");

  a_clear_held: assert property (
    (IRQ_CLEAR_IN && pending && !global_ff[CLR_CFG_BIT] && !core_rst &&
     hold_cnt_ff == '0) ##1 (pending && !core_rst) |-> IRQ_PIN_OE_OUT)
    else $error("interrupt line dropped on clear while pending");

  a_clear_release: assert property (
    s_clear_hold |=> s_released)
    else $error("interrupt line not released after clear");

  a_reassert: assert property (
    (hold_cnt_ff == HOLD_W'(1) && pending && !clr_start && !core_rst)
    |=> IRQ_PIN_OE_OUT)
    else $error("interrupt line not reasserted after window");

  a_no_source: assert property (
    (!pending) |=> !IRQ_PIN_OE_OUT)
    else $error("interrupt asserted without a masked source");

  a_logic_source: assert property (
    (STATUS_FLAGS_IN[LOGIC_BIT] && irq_mask_ff[LOGIC_BIT] &&
     hold_cnt_ff == '0 && !IRQ_CLEAR_IN && !core_rst) |=> IRQ_PIN_OE_OUT)
    else $error("logic flag did not assert interrupt");

  a_soft_reads_0: assert property (
    (REG_RD_IN && REG_ADDR_IN == ADDR_GLOBAL) |=> !REG_RDATA_OUT[SOFT_BIT])
    else $error("soft reset bit read back as set");

endmodule : gcm_global_config

// ===== hw/gcm_pkg.sv
package gcm_pkg;

  // Register addresses on the serial register port.
  localparam logic [7:0] ADDR_PIN_EXT  = 8'h3c;
  localparam logic [7:0] ADDR_GLOBAL   = 8'h3d;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h3e;

  // Reset values and writable bit masks.
  localparam logic [7:0] RST_PIN_EXT   = 8'h00;
  localparam logic [7:0] RST_GLOBAL    = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK  = 8'h00;
  localparam logic [7:0] WMASK_PIN_EXT = 8'hf9;
  localparam logic [7:0] WMASK_GLOBAL  = 8'he3;
  localparam logic [7:0] WMASK_IRQ     = 8'h17;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Field positions of the pin function extension register.
  localparam int PULL_BIT    = 7;
  localparam int COL0_ALT_BIT = 6;
  localparam int ROW4_ALT_BIT = 5;
  localparam int COL1_ALT_BIT = 4;
  localparam int ROW3_ALT_BIT = 3;
  localparam int ROW0_ALT_BIT = 0;

  // Field positions of the global control register.
  localparam int OSC_ON_BIT  = 7;
  localparam int CSEL_HI_BIT = 6;
  localparam int CSEL_LO_BIT = 5;
  localparam int SOFT_BIT    = 2;
  localparam int CLR_CFG_BIT = 1;
  localparam int PIN_IGN_BIT = 0;

  // Mask and status flag positions share one layout.
  localparam int LOGIC_BIT   = 4;
  localparam int OVFL_BIT    = 2;
  localparam int INCHG_BIT   = 1;
  localparam int EVENT_BIT   = 0;

  // Ball indices for the alternate function muxes.
  localparam int NBALL       = 5;
  localparam int BALL_COL0   = 0;
  localparam int BALL_COL1   = 1;
  localparam int BALL_ROW0   = 2;
  localparam int BALL_ROW3   = 3;
  localparam int BALL_ROW4   = 4;

  // Timing figures and derived cycle counts.
  localparam int CLK_HZ        = 100_000_000;
  localparam int BASE_OSC_HZ   = 800_000;
  localparam int BASE_DIV      = CLK_HZ / BASE_OSC_HZ;
  localparam logic [6:0] BASE_LAST = 7'(BASE_DIV - 1);
  localparam logic [4:0] CORE_DIV_SLOW = 5'h10;
  localparam int HOLDOFF_US    = 50;
  localparam int HOLDOFF_CYC   = (HOLDOFF_US * (CLK_HZ / 1_000_000));
  localparam int SOFT_WAIT_US  = 200;
  localparam int HOLD_W        = 13;

  // Per-ball drive from the GPIO block and the keypad scanner.
  typedef struct packed {
    logic gpio_o;
    logic gpio_oe;
    logic scan_o;
    logic scan_oe;
  } gcm_ball_drive_type;

endpackage : gcm_pkg

// ===== hw/gcm_ball_mux.sv
`timescale 1ns/1ps
module gcm_ball_mux (
  // Ownership controls.
  input  wire logic keypad_sel_in,
  input  wire logic alt_en_in,
  input  wire logic alt_is_input_in,
  // Candidate drivers.
  input  wire logic gpio_o_in,
  input  wire logic gpio_oe_in,
  input  wire logic scan_o_in,
  input  wire logic scan_oe_in,
  input  wire logic alt_o_in,
  // Ball side.
  input  wire logic pad_in,
  output logic      pad_o_out,
  output logic      pad_oe_out,
  output logic      gpio_i_out,
  output logic      alt_i_out
);

  logic alt_active;

  assign alt_active = alt_en_in & ~keypad_sel_in;

  // Keypad first, then alternate function, then plain GPIO.
  always_comb begin
    pad_o_out  = gpio_o_in;
    pad_oe_out = gpio_oe_in;
    if (keypad_sel_in) begin
      pad_o_out  = scan_o_in;
      pad_oe_out = scan_oe_in;
    end else if (alt_active && alt_is_input_in) begin
      pad_o_out  = 1'b0;
      pad_oe_out = 1'b0;
    end else if (alt_active) begin
      pad_o_out  = alt_o_in;
      pad_oe_out = 1'b1;
    end
  end

  // Inputs reach only the function that owns the ball.
  assign gpio_i_out = pad_in & ~keypad_sel_in & ~alt_active;
  assign alt_i_out  = pad_in & alt_active & alt_is_input_in;

endmodule : gcm_ball_mux

// ===== hw/gcm_clk_div.sv
`timescale 1ns/1ps
module gcm_clk_div
  import gcm_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Control.
  input  wire logic       osc_on_in,
  input  wire logic [1:0] sel_in,
  // Core rate tick.
  output logic            tick_out
);

  logic [6:0] base_cnt_ff;
  logic [4:0] core_cnt_ff;
  logic [4:0] core_div;
  logic       base_tick;

  // 00 divides by sixteen, each step up halves the divisor.
  assign core_div  = CORE_DIV_SLOW >> sel_in;
  assign base_tick = (base_cnt_ff == BASE_LAST);

  always_ff @(posedge clk_in) begin
    if (rst_in || !osc_on_in) begin
      base_cnt_ff <= '0;
    end else if (base_tick) begin
      base_cnt_ff <= '0;
    end else begin
      base_cnt_ff <= base_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || !osc_on_in) begin
      core_cnt_ff <= '0;
      tick_out    <= 1'b0;
    end else if (base_tick) begin
      tick_out    <= (core_cnt_ff >= core_div - 5'h01);
      core_cnt_ff <= (core_cnt_ff >= core_div - 5'h01) ? 5'h00
                     : core_cnt_ff + 5'h01;
    end else begin
      tick_out    <= 1'b0;
    end
  end

endmodule : gcm_clk_div

// ===== tb/gcm_host.sv
`timescale 1ns/1ps
module gcm_host (
  // Clock.
  input  wire logic       clk_in,
  // Read data from the device.
  input  wire logic [7:0] rdata_in,
  // Register strobes towards the device.
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out
);
  // Idle strobes from time zero so no request lands during reset.
  initial begin
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = 8'h00;
    wdata_out = 8'h00;
  end

  // One write; the idle edge that follows keeps strobes single pulses.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out    = 1'b1;
    addr_out  = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out    = 1'b0;
    wdata_out = ~d;
  endtask : wr

  // One read; data is taken once the sampling edge has passed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_out   = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    rd_out   = 1'b0;
    d        = rdata_in;
  endtask : rd

  task automatic soft_wait();
    repeat (200 * 100) @(negedge clk_in);
  endtask : soft_wait
endmodule : gcm_host

// ===== tb/gcm_global_config_tb.sv
`timescale 1ns/1ps
module gcm_global_config_tb;
  import gcm_pkg::*;
  localparam int HOLD = 20;
  logic                            clk;
  logic                            rst;
  logic                            wr;
  logic                            rd;
  logic [7:0]                      addr;
  logic [7:0]                      wdata;
  logic [7:0]                      rdata;
  logic                            pin_n;
  logic                            dev_rst;
  logic [7:0]                      status;
  logic                            irq_clr;
  logic                            irq_o;
  logic                            irq_oe;
  logic                            osc_run;
  logic                            tick;
  logic                            pull;
  logic [NBALL-1:0]                kp_sel;
  gcm_ball_drive_type [NBALL-1:0]  drive;
  logic [NBALL-1:0]                pad_in;
  logic [NBALL-1:0]                pad_o;
  logic [NBALL-1:0]                pad_oe;
  logic [NBALL-1:0]                gpio_i;
  logic [3:0]                      alt_src;
  logic                            logic_c;
  logic [7:0]                      d;
  int                              n;
  int                              num_errors;
  int                              n_compared;
  int                              bits [4] = '{4, 2, 1, 0};

  gcm_host gcm_host_i (.clk_in(clk), .rdata_in(rdata), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

  gcm_global_config #(.HOLDOFF_CYCLES(HOLD)) gcm_global_config_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .RESET_PIN_N_IN(pin_n), .DEVICE_RESET_OUT(dev_rst),
    .STATUS_FLAGS_IN(status), .IRQ_CLEAR_IN(irq_clr), .IRQ_PIN_IN(~irq_oe),
    .IRQ_PIN_OUT(irq_o), .IRQ_PIN_OE_OUT(irq_oe), .OSC_RUN_OUT(osc_run),
    .CORE_TICK_OUT(tick), .ROW_PULL_STRONG_OUT(pull),
    .KEYPAD_SEL_IN(kp_sel), .BALL_DRIVE_IN(drive), .BALL_PAD_IN(pad_in),
    .BALL_PAD_OUT(pad_o), .BALL_PAD_OE_OUT(pad_oe), .GPIO_IN_OUT(gpio_i),
    .PULSE_ONE_IN(alt_src[0]), .PULSE_TWO_IN(alt_src[1]),
    .RESET_GEN_IN(alt_src[2]), .LOGIC_OUT_IN(alt_src[3]),
    .LOGIC_THIRD_INPUT_OUT(logic_c));

  // Free running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Byte results; case inequality so unknowns never match.
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, act, exp);
    end
  endtask : chk

  // Cycle counts measured by the bench.
  task automatic chk_n(input int act, input int exp);
    n_compared++;
    if (act != exp) begin
      num_errors++;
      $display("[ERR] %0t count %0d want %0d", $time, act, exp);
    end
  endtask : chk_n

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Bounded wait for the next core tick, returning cycles waited.
  task automatic tick_gap(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tick !== 1'b1 && k < 5000);
  endtask : tick_gap

  task automatic results();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Watchdog sized well beyond the roughly 31.5k cycles the tests need.
  initial begin
    #900_000;
    num_errors++;
    results();
  end

  initial begin
    rst = 1'b1; pin_n = 1'b1; status = 8'h00; irq_clr = 1'b0;
    kp_sel = '0; drive = '1; pad_in = '1; alt_src = 4'h0;
    num_errors = 0; n_compared = 0;
    cyc(16);
    rst = 1'b0;
    // Reset values, unmapped read and write masks.
    foreach (bits[i]) begin
      gcm_host_i.rd(8'h3c + 8'(i), d);
      chk(d, 8'h00);
    end
    gcm_host_i.wr(8'h3c, 8'hff);
    gcm_host_i.rd(8'h3c, d);
    chk(d, 8'hf9);
    gcm_host_i.wr(8'h3d, 8'he3);
    gcm_host_i.rd(8'h3d, d);
    chk(d, 8'he3);
    gcm_host_i.wr(8'h3e, 8'hff);
    gcm_host_i.rd(8'h3e, d);
    chk(d, 8'h17);
    // Pull strength and alternate functions against keypad ownership.
    cyc(2);
    chk({7'h0, pull}, 8'h01);
    chk({3'h0, pad_o & 5'h17}, 8'h00);
    chk({7'h0, logic_c}, 8'h01);
    chk({3'h0, pad_oe}, 8'h17);
    chk({3'h0, gpio_i}, 8'h00);
    alt_src = 4'hf;
    cyc(2);
    chk({3'h0, pad_o & 5'h17}, 8'h17);
    alt_src = 4'h0; kp_sel = '1;
    cyc(2);
    chk({3'h0, pad_o & 5'h17}, 8'h17);
    chk({3'h0, pad_oe}, 8'h1f);
    chk({3'h0, gpio_i}, 8'h00);
    kp_sel = '0;
    gcm_host_i.wr(8'h3c, 8'h00);
    cyc(2);
    chk({6'h0, pull, logic_c}, 8'h00);
    chk({3'h0, pad_o & 5'h17}, 8'h17);
    chk({3'h0, pad_oe}, 8'h1f);
    chk({3'h0, gpio_i}, 8'h1f);
    // Each mask gates only its own flag.
    foreach (bits[i]) begin
      gcm_host_i.wr(8'h3e, 8'h01 << bits[i]);
      status = 8'h17 & ~(8'h01 << bits[i]);
      cyc(2);
      chk({7'h0, irq_oe}, 8'h00);
      status = 8'h01 << bits[i];
      cyc(2);
      chk({7'h0, irq_oe}, 8'h01);
    end
    // Clear while pending, both behaviours.
    gcm_host_i.wr(8'h3d, 8'h00);
    irq_clr = 1'b1; cyc(1); irq_clr = 1'b0; cyc(1);
    chk({7'h0, irq_oe}, 8'h01);
    chk({7'h0, irq_o}, 8'h00);
    gcm_host_i.wr(8'h3d, 8'h02);
    irq_clr = 1'b1; cyc(1); irq_clr = 1'b0; cyc(1);
    chk({7'h0, irq_oe}, 8'h00);
    cyc(HOLD - 2);
    chk({7'h0, irq_oe}, 8'h00);
    cyc(4);
    chk({7'h0, irq_oe}, 8'h01);
    // Core rate for every select value.
    for (int s = 0; s < 4; s++) begin
      gcm_host_i.wr(8'h3d, 8'h80 | 8'(s << 5));
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      chk_n(n, 125 * (16 >> s));
      chk({7'h0, osc_run}, 8'h01);
    end
    gcm_host_i.wr(8'h3d, 8'h00);
    cyc(2);
    chk({7'h0, osc_run}, 8'h00);
    // Soft reset pulses the device reset and clears registers.
    gcm_host_i.wr(8'h3e, 8'h17);
    gcm_host_i.wr(8'h3d, 8'h84);
    chk({7'h0, dev_rst}, 8'h01);
    gcm_host_i.soft_wait();
    chk({7'h0, dev_rst}, 8'h00);
    gcm_host_i.rd(8'h3e, d);
    chk(d, 8'h00);
    gcm_host_i.rd(8'h3d, d);
    chk(d, 8'h00);
    // Reset pin honoured, then ignored.
    gcm_host_i.wr(8'h3c, 8'h08);
    pin_n = 1'b0; cyc(3);
    chk({7'h0, dev_rst}, 8'h01);
    pin_n = 1'b1; cyc(3);
    gcm_host_i.rd(8'h3c, d);
    chk(d, 8'h00);
    gcm_host_i.wr(8'h3d, 8'h01);
    gcm_host_i.wr(8'h3c, 8'h08);
    pin_n = 1'b0; cyc(3);
    chk({7'h0, dev_rst}, 8'h00);
    gcm_host_i.rd(8'h3c, d);
    chk(d, 8'h08);
    pin_n = 1'b1;
    results();
  end
endmodule : gcm_global_config_tb
